// ==== src/lsc_pkg.sv ====
package lsc_pkg;

   // Configuration offsets (byte addresses, dword aligned)
   localparam logic [7:0]  LSC_OFS_LEGACY_BASE = 8'h44;
   localparam logic [7:0]  LSC_OFS_SYSCTL      = 8'h80;

   // Reset values
   localparam logic [31:0] LSC_LEGACY_RESET    = 32'h0000_0001;
   localparam logic [31:0] LSC_SYSCTL_RESET    = 32'h0044_9060;

   // System control field positions
   localparam int          LSC_SHIFT_HI        = 31;
   localparam int          LSC_SHIFT_LO        = 30;
   localparam int          LSC_TIE_BIT         = 29;
   localparam int          LSC_RSVD_BIT        = 28;
   localparam int          LSC_CLKSRC_BIT      = 27;
   localparam int          LSC_ROUTE_BIT       = 26;
   localparam int          LSC_FLAG_BIT        = 25;
   localparam int          LSC_ENABLE_BIT      = 24;
   localparam int          LSC_UPPER_LANE      = 3;
   localparam int          LSC_LOW_BITS        = 24;

   // Legacy window: index at base, data at base plus one
   localparam logic [31:0] LSC_DATA_STEP       = 32'h0000_0001;

   // Function that owns the global bits
   localparam logic        LSC_GLOBAL_FUNC     = 1'b0;

   // Internal oscillator half period, in clk cycles
   localparam int          LSC_OSC_HALF_DEF    = 4;

   // Interrupt slot positions in the serial stream
   typedef enum logic [1:0] {
      LSC_SLOT_A = 2'b00,
      LSC_SLOT_B = 2'b01,
      LSC_SLOT_C = 2'b10,
      LSC_SLOT_D = 2'b11
   } lsc_slot_e;

endpackage

// ==== src/lsc_slot_map.sv ====
`timescale 1ns/100ps
module lsc_slot_map
   import lsc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Configuration
   input  wire lsc_slot_e  slot_shift,
   input  wire logic       line_tie,
   // Internal interrupt sources
   input  wire logic       src_first,
   input  wire logic       src_second,
   // Slot levels in the serial stream
   output logic [3:0]      slot_req_q
);

   logic       line_first;    // Level sent as the first line
   logic       line_second;   // Level sent as the second line
   logic [1:0] second_pos;    // Slot that follows the first
   logic [3:0] slot_req_d;    // Next slot levels

   // Tie folds both sources onto the first line
   always_comb begin
      line_first  = line_tie ? (src_first | src_second) : src_first;
      line_second = line_tie ? 1'b0 : src_second;
      second_pos  = 2'(slot_shift + 2'd1);
      slot_req_d  = '0;
      slot_req_d[slot_shift] = line_first;
      slot_req_d[second_pos] = slot_req_d[second_pos] | line_second;
   end

   // Registered so the stream serializer sees clean levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_req_q <= '0;
      end else begin
         slot_req_q <= slot_req_d;
      end
   end

endmodule

// ==== src/lsc_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Base decodes index, base plus one data
// - Base placed anywhere in I/O, word aligned
// - Base bit 0 reads one, read-only
// - One legacy base shared by both functions
// - Global control bits single copy, function 0
// - Slot shift places two lines in stream
// - Tie merges both sources onto first line
// - Reserved bit 28 always reads zero
// - Bit 27 selects external or internal clock
// - Power write raises IRQ2 or status change
// - Per-socket flag set on enabled power write, W1C
// - Enabled power write pulses management interrupt
module lsc_top
   import lsc_pkg::*;
#(
   parameter int OSC_HALF = LSC_OSC_HALF_DEF   // Internal oscillator half period
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Configuration access
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic        cfg_func,
   input  wire logic [7:0]  cfg_offset,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata_q,
   output logic             cfg_rvalid_q,
   // I/O address decode
   input  wire logic        io_valid,
   input  wire logic [31:0] io_addr,
   output logic             io_index_hit,
   output logic             io_data_hit,
   // Socket power writes, one bit per socket
   input  wire logic [1:0]  power_wr,
   // Power write interrupts
   output logic             irq2_pulse_q,
   output logic [1:0]       card_status_change_q,
   output logic             system_management_interrupt_q,
   // Internal interrupt sources and stream slots
   input  wire logic        int_src_first,
   input  wire logic        int_src_second,
   output logic [3:0]       slot_req_q,
   // Power switch clock pin
   input  wire logic        psw_clk_in,
   output logic             psw_clk_out_q,
   output logic             psw_clk_oe_n,
   output logic             psw_clk_tick_q
);

   // Oscillator counter must hold the half period
   if (OSC_HALF < 1 || OSC_HALF > 255) begin : g_chk
      $error("OSC_HALF out of range");
   end

   logic [31:0] legacy_base_q;     // Shared legacy base, one copy
   logic [1:0]  slot_shift_q;      // Global slot shift
   logic        line_tie_q;        // Global interrupt tie
   logic        clk_source_q;      // Global clock source select
   logic        event_route_q;     // Shared route select
   logic        event_enable_q;    // Global management enable
   logic [1:0]  event_flag_q;      // Per-socket event flags
   logic        wr_legacy;         // Write strobe, legacy base
   logic        wr_sysctl;         // Write strobe, system control
   logic        wr_upper;          // Upper byte written
   logic        wr_global;         // Global bits may change
   logic [31:0] base_view;         // Base as software reads it
   logic [31:0] read_mux;          // Combinational read value

   // Decode used by both write and read paths
   function automatic logic hit(input logic [7:0] ofs, input logic [7:0] want);
      hit = (ofs == want);
   endfunction

   // Register write strobes
   always_comb begin
      wr_legacy = cfg_wr && hit(cfg_offset, LSC_OFS_LEGACY_BASE);
      wr_sysctl = cfg_wr && hit(cfg_offset, LSC_OFS_SYSCTL);
      wr_upper  = wr_sysctl && cfg_be[LSC_UPPER_LANE];
      wr_global = wr_upper && (cfg_func == LSC_GLOBAL_FUNC);
   end

   // Legacy base; function number plays no part
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         legacy_base_q <= LSC_LEGACY_RESET;
      end else if (wr_legacy) begin
         for (int b = 0; b < 4; b++) begin
            if (cfg_be[b]) begin
               legacy_base_q[b*8 +: 8] <= cfg_wdata[b*8 +: 8];
            end
         end
      end
   end

   // Bit 0 is forced, so the stored bit is never seen
   assign base_view = {legacy_base_q[31:1], LSC_LEGACY_RESET[0]};

   // I/O decode of the index/data pair
   always_comb begin
      io_index_hit = io_valid && (io_addr == {base_view[31:1], 1'b0});
      io_data_hit  = io_valid &&
                     (io_addr == ({base_view[31:1], 1'b0} + LSC_DATA_STEP));
   end

   // Global control bits, function 0 only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_shift_q   <= LSC_SYSCTL_RESET[LSC_SHIFT_HI:LSC_SHIFT_LO];
         line_tie_q     <= LSC_SYSCTL_RESET[LSC_TIE_BIT];
         clk_source_q   <= LSC_SYSCTL_RESET[LSC_CLKSRC_BIT];
         event_enable_q <= LSC_SYSCTL_RESET[LSC_ENABLE_BIT];
      end else if (wr_global) begin
         slot_shift_q   <= cfg_wdata[LSC_SHIFT_HI:LSC_SHIFT_LO];
         line_tie_q     <= cfg_wdata[LSC_TIE_BIT];
         clk_source_q   <= cfg_wdata[LSC_CLKSRC_BIT];
         event_enable_q <= cfg_wdata[LSC_ENABLE_BIT];
      end
   end

   // Route bit is shared but writable from either function
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_route_q <= LSC_SYSCTL_RESET[LSC_ROUTE_BIT];
      end else if (wr_upper) begin
         event_route_q <= cfg_wdata[LSC_ROUTE_BIT];
      end
   end

   // Per-socket flags; a set in the clear cycle wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_flag_q <= '0;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (event_enable_q && power_wr[s]) begin
               event_flag_q[s] <= 1'b1;
            end else if (wr_upper && cfg_func == 1'(s) && cfg_wdata[LSC_FLAG_BIT]) begin
               event_flag_q[s] <= 1'b0;
            end
         end
      end
   end

   // Power write interrupt pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq2_pulse_q                  <= 1'b0;
         card_status_change_q          <= '0;
         system_management_interrupt_q <= 1'b0;
      end else begin
         irq2_pulse_q         <= (|power_wr) && !event_route_q;
         card_status_change_q <= event_route_q ? power_wr : 2'b00;
         system_management_interrupt_q <= (|power_wr) && event_enable_q;
      end
   end

   // Read mux; the flag shown is the reading function's socket
   always_comb begin
      read_mux = '0;
      if (hit(cfg_offset, LSC_OFS_LEGACY_BASE)) begin
         read_mux = base_view;
      end else if (hit(cfg_offset, LSC_OFS_SYSCTL)) begin
         read_mux = LSC_SYSCTL_RESET;   // Lower bits live elsewhere
         read_mux[LSC_SHIFT_HI:LSC_SHIFT_LO] = slot_shift_q;
         read_mux[LSC_TIE_BIT]    = line_tie_q;
         read_mux[LSC_RSVD_BIT]   = 1'b0;
         read_mux[LSC_CLKSRC_BIT] = clk_source_q;
         read_mux[LSC_ROUTE_BIT]  = event_route_q;
         read_mux[LSC_FLAG_BIT]   = event_flag_q[cfg_func];
         read_mux[LSC_ENABLE_BIT] = event_enable_q;
      end
   end

   // Read data answered one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_rdata_q  <= '0;
         cfg_rvalid_q <= 1'b0;
      end else begin
         cfg_rvalid_q <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata_q <= read_mux;
         end
      end
   end

   // Interrupt slot placement
   lsc_slot_map u_slot_map (
      .clk        (clk),
      .rst        (rst),
      .slot_shift (lsc_slot_e'(slot_shift_q)),
      .line_tie   (line_tie_q),
      .src_first  (int_src_first),
      .src_second (int_src_second),
      .slot_req_q (slot_req_q)
   );

   // Power switch clock: divider stands in for the ring oscillator
   logic [7:0] osc_cnt_q;      // Half period counter
   logic       ext_sync1_q;    // Pin synchroniser, first stage
   logic       ext_sync2_q;    // Pin synchroniser, second stage
   logic       ext_prev_q;     // Previous synced level
   logic       osc_rise;       // Internal clock rising this cycle

   assign osc_rise = (osc_cnt_q == 8'(OSC_HALF - 1)) && !psw_clk_out_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_cnt_q     <= '0;
         psw_clk_out_q <= 1'b0;
      end else if (!clk_source_q || (wr_global && !cfg_wdata[LSC_CLKSRC_BIT])) begin
         osc_cnt_q     <= '0;
         psw_clk_out_q <= 1'b0;
      end else if (osc_cnt_q == 8'(OSC_HALF - 1)) begin
         osc_cnt_q     <= '0;
         psw_clk_out_q <= !psw_clk_out_q;
      end else begin
         osc_cnt_q <= 8'(osc_cnt_q + 8'd1);
      end
   end

   // Pin is driven only when the internal source is chosen
   assign psw_clk_oe_n = !clk_source_q;

   // External clock is sampled through two flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_sync1_q <= 1'b0;
         ext_sync2_q <= 1'b0;
         ext_prev_q  <= 1'b0;
      end else begin
         ext_sync1_q <= psw_clk_in;
         ext_sync2_q <= ext_sync1_q;
         ext_prev_q  <= ext_sync2_q;
      end
   end

   // Tick that advances the power switch state machine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psw_clk_tick_q <= 1'b0;
      end else begin
         psw_clk_tick_q <= clk_source_q ? osc_rise : (ext_sync2_q && !ext_prev_q);
      end
   end

   // Checks
   property p_base_bit0;
      @(posedge clk) disable iff (rst) cfg_rvalid_q && $past(cfg_rd) &&
         $past(cfg_offset) == LSC_OFS_LEGACY_BASE |-> cfg_rdata_q[0];
   endproperty
   a_base_bit0: assert property (p_base_bit0) else $error("base bit0 not one");

   property p_rsvd;
      @(posedge clk) disable iff (rst) cfg_rvalid_q && $past(cfg_offset) == LSC_OFS_SYSCTL
         |-> !cfg_rdata_q[LSC_RSVD_BIT];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   property p_data_hit;
      @(posedge clk) disable iff (rst) io_data_hit |-> io_addr[0] && !io_index_hit;
   endproperty
   a_data_hit: assert property (p_data_hit) else $error("data port decode wrong");

   property p_func1_global;
      @(posedge clk) disable iff (rst) cfg_wr && cfg_func && !power_wr[0] ##1 1
         |-> $stable(line_tie_q) && $stable(slot_shift_q) && $stable(event_enable_q);
   endproperty
   a_func1_global: assert property (p_func1_global) else $error("func1 changed global");

   property p_shared_base;
      @(posedge clk) disable iff (rst) wr_legacy && cfg_be == 4'hF
         |=> legacy_base_q[31:1] == $past(cfg_wdata[31:1]);
   endproperty
   a_shared_base: assert property (p_shared_base) else $error("base write lost");

   property p_smi;
      @(posedge clk) disable iff (rst) (|power_wr) && event_enable_q
         |=> system_management_interrupt_q;
   endproperty
   a_smi: assert property (p_smi) else $error("management pulse missing");

   property p_flag_set;
      @(posedge clk) disable iff (rst) power_wr[1] && event_enable_q |=> event_flag_q[1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_route;
      @(posedge clk) disable iff (rst) power_wr[0] && event_route_q
         |=> card_status_change_q[0] && !irq2_pulse_q;
   endproperty
   a_route: assert property (p_route) else $error("route wrong");

   property p_clk_oe;
      @(posedge clk) disable iff (rst) !clk_source_q |-> psw_clk_oe_n && !psw_clk_out_q;
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("pin driven on external");

   property p_tie;
      @(posedge clk) disable iff (rst) line_tie_q && !int_src_first && int_src_second
         && $stable(line_tie_q) && $stable(slot_shift_q)
         |=> slot_req_q[$past(slot_shift_q)] && $countones(slot_req_q) == 1;
   endproperty
   a_tie: assert property (p_tie) else $error("tie not folded");

   c_smi:   cover property (@(posedge clk) disable iff (rst) system_management_interrupt_q);
   c_tie:   cover property (@(posedge clk) disable iff (rst) line_tie_q && |slot_req_q);
   c_iodat: cover property (@(posedge clk) disable iff (rst) io_data_hit);
   c_osc:   cover property (@(posedge clk) disable iff (rst) clk_source_q && psw_clk_tick_q);

endmodule

// ==== tb/lsc_host.sv ====
`timescale 1ns/100ps
// Host side of the configuration bus: strobed single accesses
module lsc_host (
   // Clock
   input  wire logic        clk,
   // Configuration access
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic             cfg_func,
   output logic [7:0]       cfg_offset,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata,
   input  wire logic [31:0] cfg_rdata_q,
   input  wire logic        cfg_rvalid_q
);
   // Idle lines start away from any real request
   initial begin
      cfg_wr     = 1'b0;
      cfg_rd     = 1'b0;
      cfg_func   = 1'b1;
      cfg_offset = 8'hff;
      cfg_be     = 4'h0;
      cfg_wdata  = 32'ha5a5_5a5a;
   end

   // Qualifiers set just after an edge
   task automatic put(input logic f, input logic [7:0] ofs, input logic [3:0] be,
                      input logic [31:0] d);
      cfg_func   = f;
      cfg_offset = ofs;
      cfg_be     = be;
      cfg_wdata  = d;
   endtask

   // Released lines show the inverse, so stale values never look valid
   task automatic release_bus();
      cfg_func   = ~cfg_func;
      cfg_offset = ~cfg_offset;
      cfg_be     = ~cfg_be;
      cfg_wdata  = ~cfg_wdata;
   endtask

   // One write, strobe held for exactly the taking edge
   task automatic wr(input logic f, input logic [7:0] ofs, input logic [3:0] be,
                     input logic [31:0] d);
      @(posedge clk);
      #1;
      put(f, ofs, be, d);
      cfg_wr = 1'b1;
      @(posedge clk);
      #1;
      cfg_wr = 1'b0;
      release_bus();
   endtask

   // One read; data taken while the valid pulse stands
   task automatic rd(input logic f, input logic [7:0] ofs, output logic [31:0] d,
                     output logic ok);
      ok = 1'b0;
      d  = 32'h0000_0000;
      @(posedge clk);
      #1;
      put(f, ofs, 4'hf, ~cfg_wdata);
      cfg_rd = 1'b1;
      @(posedge clk);
      #1;
      cfg_rd = 1'b0;
      // Bounded wait, the pulse may not come at all
      for (int i = 0; i < 4 && !ok; i++) begin
         if (cfg_rvalid_q === 1'b1) begin
            d  = cfg_rdata_q;
            ok = 1'b1;
         end else begin
            @(posedge clk);
            #1;
         end
      end
      release_bus();
   endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
// Self-checking bench for the legacy index and system control block
module tb;
   import lsc_pkg::*;
   localparam int OSC = 4;             // Divider half period used here
   logic        clk, rst;              // Clock and reset
   logic        cfg_wr, cfg_rd, cfg_func, cfg_rvalid_q;
   logic [7:0]  cfg_offset;            // Config offset
   logic [3:0]  cfg_be;                // Byte enables
   logic [31:0] cfg_wdata, cfg_rdata_q;
   logic        io_valid, io_index_hit, io_data_hit;
   logic [31:0] io_addr;               // I/O address under test
   logic [1:0]  power_wr, card_status_change;         // Power writes, status change pulses
   logic        irq2, system_management_interrupt;             // Power write interrupts
   logic        src_a, src_b;          // Internal interrupt sources
   logic [3:0]  slot_req_q;            // Stream slot levels
   logic        psw_in, psw_out, psw_oe_n, psw_tick;
   int          failures, checked;     // Report counters
   logic [23:0] lo;                    // Untouched low system control bits
   int          n, m;                  // Edge counters
   logic        prev;                  // Last sampled clock out

   // Host model drives the configuration bus
   lsc_host i_lsc_host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func),
      .cfg_offset(cfg_offset), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q));

   // Block under test, short oscillator divider
   lsc_top #(.OSC_HALF(OSC)) i_lsc_top (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_offset(cfg_offset), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
      .io_valid(io_valid), .io_addr(io_addr), .io_index_hit(io_index_hit),
      .io_data_hit(io_data_hit), .power_wr(power_wr), .irq2_pulse_q(irq2),
      .card_status_change_q(card_status_change), .system_management_interrupt_q(system_management_interrupt),
      .int_src_first(src_a), .int_src_second(src_b), .slot_req_q(slot_req_q),
      .psw_clk_in(psw_in), .psw_clk_out_q(psw_out), .psw_clk_oe_n(psw_oe_n),
      .psw_clk_tick_q(psw_tick));

   // 25 ns clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compare one value
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Read through the host and compare
   task automatic rdc(input logic f, input logic [7:0] ofs, input logic [31:0] e);
      logic [31:0] d;
      logic        ok;
      i_lsc_host.rd(f, ofs, d, ok);
      if (!ok) begin
         failures++;
         $display("[ERR] read valid expected 1 seen 0");
         test_done();
      end else begin
         chk($sformatf("read f%0d ofs %h", f, ofs), e, d);
      end
   endtask

   // Settle c edges, then step off the edge
   task automatic go(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   // Write the upper system control byte
   task automatic sc(input logic f, input logic [7:0] b);
      i_lsc_host.wr(f, LSC_OFS_SYSCTL, 4'h8, {b, 24'h00_0000});
   endtask

   // One-cycle socket power write
   task automatic pw(input logic [1:0] v);
      @(posedge clk);
      #1;
      power_wr = v;
      go(1);
      power_wr = 2'b00;
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      io_valid = 1'b0;
      io_addr = 32'h0000_0000;
      power_wr = 2'b00;
      src_a = 1'b0;
      src_b = 1'b0;
      psw_in = 1'b0;
      failures = 0;
      checked = 0;
      lo = LSC_SYSCTL_RESET[23:0];
      go(3);
      rst = 1'b0;
      // Reset values, unmapped offset
      rdc(0, LSC_OFS_LEGACY_BASE, 32'h0000_0001);
      rdc(1, LSC_OFS_SYSCTL, 32'h0044_9060);
      rdc(0, 8'h40, 32'h0000_0000);
      // Shared base, bit 0 stuck at one, byte lanes
      i_lsc_host.wr(0, LSC_OFS_LEGACY_BASE, 4'hf, 32'h1234_5678);
      rdc(1, LSC_OFS_LEGACY_BASE, 32'h1234_5679);
      i_lsc_host.wr(1, LSC_OFS_LEGACY_BASE, 4'h1, 32'hffff_ffaa);
      rdc(0, LSC_OFS_LEGACY_BASE, 32'h1234_56ab);
      // Index at base, data at base plus one; address moves just after an edge
      io_valid = 1'b1;
      for (int k = 0; k < 3; k++) begin
         io_addr = 32'h1234_56aa + k;
         go(1);
         chk("index hit", k == 0, io_index_hit);
         chk("data hit", k == 1, io_data_hit);
      end
      io_valid = 1'b0;
      go(1);
      chk("data hit idle", 0, io_data_hit);
      // Function 1 may only move the shared route bit and clear its own socket flag
      sc(1, 8'hff);
      rdc(0, LSC_OFS_SYSCTL, {8'h04, lo});
      sc(0, 8'hff);
      rdc(1, LSC_OFS_SYSCTL, {8'hed, lo});
      // Slot placement, separate and tied lines
      for (int t = 0; t < 2; t++) begin
         for (int s = 0; s < 4; s++) begin
            sc(0, {s[1:0], t[0], 5'h00});
            src_a = 1'b1;
            src_b = 1'b0;
            go(2);
            chk("slot first", 4'b0001 << s, slot_req_q);
            src_a = 1'b0;
            src_b = 1'b1;
            go(2);
            chk("slot second", t ? 4'b0001 << s : 4'b0001 << ((s + 1) % 4),
                slot_req_q);
         end
      end
      src_b = 1'b0;
      // Route to IRQ2, management disabled
      sc(0, 8'h00);
      pw(2'b01);
      chk("irq2", 1, irq2);
      chk("smi off", 0, {card_status_change, system_management_interrupt});
      go(1);
      chk("irq2 pulse", 0, irq2);
      rdc(0, LSC_OFS_SYSCTL, {8'h00, lo});
      // Route to status change, management enabled
      sc(0, 8'h05);
      pw(2'b10);
      chk("csc", 3'b101, {card_status_change, system_management_interrupt});
      chk("irq2 off", 0, irq2);
      rdc(1, LSC_OFS_SYSCTL, {8'h07, lo});
      rdc(0, LSC_OFS_SYSCTL, {8'h05, lo});
      sc(1, 8'h06);
      rdc(1, LSC_OFS_SYSCTL, {8'h05, lo});
      // Socket 0 flag: set, cleared through its own function, set wins a tie
      pw(2'b01);
      chk("csc 0", 3'b011, {card_status_change, system_management_interrupt});
      rdc(0, LSC_OFS_SYSCTL, {8'h07, lo});
      rdc(1, LSC_OFS_SYSCTL, {8'h05, lo});
      sc(0, 8'h07);
      rdc(0, LSC_OFS_SYSCTL, {8'h05, lo});
      fork
         sc(0, 8'h07);
         pw(2'b01);
      join
      rdc(0, LSC_OFS_SYSCTL, {8'h07, lo});
      // External clock pin
      sc(0, 8'h00);
      chk("oe ext", 1, psw_oe_n);
      psw_in = 1'b1;
      n = 0;
      for (int k = 0; k < 8; k++) begin
         go(1);
         n += (psw_tick === 1'b1);
      end
      chk("ext ticks", 1, n);
      psw_in = 1'b0;
      // Internal oscillator drives the pin
      sc(0, 8'h08);
      chk("oe int", 0, psw_oe_n);
      go(8);
      prev = psw_out;
      n = 0;
      m = 0;
      for (int k = 0; k < 8 * OSC; k++) begin
         go(1);
         n += (psw_tick === 1'b1);
         m += (psw_out === 1'b1 && prev === 1'b0);
         prev = psw_out;
      end
      chk("int ticks", 4, n);
      chk("int edges", 4, m);
      // Second reset in mid-run
      rst = 1'b1;
      go(1);
      rst = 1'b0;
      chk("oe reset", 1, psw_oe_n);
      rdc(0, LSC_OFS_LEGACY_BASE, 32'h0000_0001);
      rdc(0, LSC_OFS_SYSCTL, 32'h0044_9060);
      test_done();
   end
endmodule
